/* rtl/panel_pmic_pkg.sv */
// Constants shared by the panel power module control logic
package panel_pmic_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_DISCHARGE   = 8'h12;
	localparam logic [7:0] ADDR_SLEW        = 8'h13;
	localparam logic [7:0] ADDR_SPREAD      = 8'h14;
	localparam logic [7:0] ADDR_REFRESH     = 8'h17;
	localparam logic [7:0] ADDR_OFF_DLY_POS = 8'h18;
	localparam logic [7:0] ADDR_OFF_DLY_NEG = 8'h19;
	localparam logic [7:0] ADDR_OFF_DLY_GH  = 8'h1a;
	localparam logic [7:0] ADDR_OFF_DLY_GL  = 8'h1b;
	localparam logic [7:0] ADDR_OFF_DLY_CV  = 8'h1c;
	localparam logic [7:0] ADDR_FAULT_REC   = 8'h1d;
	localparam logic [7:0] ADDR_STORE_SEL   = 8'hff;

	// Channel order: 0 pos source, 1 neg source, 2 gate high, 3 gate low, 4 common voltage
	localparam int NUM_CH   = 5;
	localparam int NUM_SW   = 4;
	localparam int NUM_SLOT = 9;
	localparam logic [3:0] SLOT_NONE = 4'h0f;
	localparam logic [3:0] SLOT_SLEW = 4'h1;
	localparam logic [3:0] SLOT_SPRD = 4'h2;
	localparam logic [3:0] SLOT_REFR = 4'h3;
	localparam logic [3:0] SLOT_DLY0 = 4'h4;
	localparam logic [3:0] SLOT_LAST = 4'h8;
	localparam logic [3:0] SLOT_DISC = 4'h0;

	// Field positions
	localparam int DISCH_MSB         = 4;
	localparam int RESET_SYNC_BIT    = 7;
	localparam int OFF_DLY_MSB       = 2;
	localparam int CLR_SEL_BIT       = 3;
	localparam int STORE_COMMIT_BIT  = 7;
	localparam int STORE_READ_BIT    = 0;
	localparam int REFRESH_EN_BIT    = 0;
	localparam int REFRESH_INT_LSB   = 1;
	localparam int REFRESH_FAULT_BIT = 3;
	localparam int SPREAD_LSB        = 3;

	// Reset values
	localparam logic [7:0] WORK_RESET  = 8'h00;
	localparam logic [7:0] STORE_RESET = 8'h00;

	// Nonvolatile store geometry
	localparam int NV_DEPTH = 32;
	localparam int NV_AW    = 5;

	// Timing
	localparam int CLK_PERIOD_NS         = 25;
	localparam int MS_NS                 = 1_000_000;
	localparam int CYCLES_PER_MS_DEFAULT = MS_NS / CLK_PERIOD_NS;
	localparam logic [5:0] ON_DISCHARGE_START_MS = 6'h01;
	localparam logic [5:0] OFF_STEP_MS           = 6'h02;
	localparam logic [5:0] OFF_DELAY_MAX_MS      = 6'h0e;
	localparam logic [5:0] DISCHARGE_WINDOW_MS   = 6'h02;
	localparam logic [5:0] UV_FILTER_MS          = 6'h32;
	localparam logic [5:0] FAULT_PULSE_MS        = 6'h01;
	localparam logic [7:0] REFRESH_MS_0          = 8'h0a;
	localparam logic [7:0] REFRESH_MS_1          = 8'h14;
	localparam logic [7:0] REFRESH_MS_2          = 8'h32;
	localparam logic [7:0] REFRESH_MS_3          = 8'h64;

endpackage

/* rtl/nv_store_mem.sv */
// Nonvolatile settings store with registered read data
`timescale 1ns/100ps
module nv_store_mem #(
	parameter int DEPTH = 32,
	parameter int AW    = 5,
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// Access port
	input  wire logic [AW-1:0]    addr_in,
	input  wire logic             wr_in,
	input  wire logic [WIDTH-1:0] wdata_in,
	output logic      [WIDTH-1:0] rdata_out
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	initial begin
		if (DEPTH > (1 << AW) || DEPTH < 1) begin
			$error("nv_store_mem: depth does not fit address width");
		end
	end

	// Cleared on reset as a stand-in for factory contents
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (wr_in) begin
			mem_reg[addr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= mem_reg[addr_in];
		end
	end

endmodule

/* rtl/panel_pmic_shutdown_fault_ctrl.sv */
// Discharge, power-off delay, fault response and settings control of the panel power module
`timescale 1ns/100ps
module panel_pmic_shutdown_fault_ctrl
	import panel_pmic_pkg::*;
#(
	parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEFAULT
) (
	// Clock and reset
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RST_IN,
	// Supply and enable monitors
	input  wire logic        EN_PIN_IN,
	input  wire logic        VIN_ABOVE_RISE_IN,
	input  wire logic        VIN_BELOW_FALL_IN,
	input  wire logic        VIN_DETECT_LOW_IN,
	// Channel monitors
	input  wire logic [4:0]  PON_DELAY_DONE_IN,
	input  wire logic [3:0]  OVP_IN,
	input  wire logic [3:0]  UVP_IN,
	input  wire logic [3:0]  SCP_IN,
	input  wire logic        OTP_IN,
	input  wire logic        COMMON_VOLTAGE_OUT_OCP_IN,
	// Register port
	input  wire logic [7:0]  REG_ADDR_IN,
	input  wire logic [7:0]  REG_WDATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	output logic      [7:0]  REG_RDATA_OUT,
	output logic             REG_RVALID_OUT,
	// Power control
	output logic      [4:0]  CH_ENABLE_OUT,
	output logic      [4:0]  DISCHARGE_OUT,
	output logic      [3:0]  SWITCH_STOP_OUT,
	output logic             COMMON_VOLTAGE_OUT_CLAMP_OUT,
	output logic             RESET_N_OUT,
	output logic             SETTINGS_LOAD_DONE_OUT,
	// Switching settings
	output logic      [1:0]  SLEW_POS_BOOST_OUT,
	output logic      [1:0]  SLEW_NEG_RAIL_OUT,
	output logic      [1:0]  SLEW_GATE_LOW_OUT,
	output logic      [1:0]  SLEW_GATE_HIGH_OUT,
	output logic      [1:0]  SPREAD_SEL_OUT,
	// Fault pin, open drain
	output logic             FAULT_OUT,
	output logic             FAULT_OE_N_OUT
);

	typedef enum {PWR_OFF, PWR_LOAD, PWR_ON, PWR_DOWN, PWR_LATCH} power_state_type;
	typedef enum {SEQ_IDLE, SEQ_READ, SEQ_CMP} seq_state_type;

	initial begin
		if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 65536) begin
			$error("panel_pmic_shutdown_fault_ctrl: CYCLES_PER_MS out of range");
		end
	end

	// Register address to working slot
	function automatic logic [3:0] slot_of(input logic [7:0] addr);
		case (addr)
			ADDR_DISCHARGE:   slot_of = SLOT_DISC;
			ADDR_SLEW:        slot_of = SLOT_SLEW;
			ADDR_SPREAD:      slot_of = SLOT_SPRD;
			ADDR_REFRESH:     slot_of = SLOT_REFR;
			ADDR_OFF_DLY_POS: slot_of = SLOT_DLY0;
			ADDR_OFF_DLY_NEG: slot_of = 4'(SLOT_DLY0 + 4'h1);
			ADDR_OFF_DLY_GH:  slot_of = 4'(SLOT_DLY0 + 4'h2);
			ADDR_OFF_DLY_GL:  slot_of = 4'(SLOT_DLY0 + 4'h3);
			ADDR_OFF_DLY_CV:  slot_of = SLOT_LAST;
			default:          slot_of = SLOT_NONE;
		endcase
	endfunction

	// Working slot to register address
	function automatic logic [7:0] addr_of(input logic [3:0] slot);
		case (slot)
			SLOT_DISC: addr_of = ADDR_DISCHARGE;
			SLOT_SLEW: addr_of = ADDR_SLEW;
			SLOT_SPRD: addr_of = ADDR_SPREAD;
			SLOT_REFR: addr_of = ADDR_REFRESH;
			default:   addr_of = 8'(ADDR_OFF_DLY_POS + 8'(slot - SLOT_DLY0));
		endcase
	endfunction

	function automatic logic [7:0] refresh_ms(input logic [1:0] sel);
		case (sel)
			2'h0:    refresh_ms = REFRESH_MS_0;
			2'h1:    refresh_ms = REFRESH_MS_1;
			2'h2:    refresh_ms = REFRESH_MS_2;
			default: refresh_ms = REFRESH_MS_3;
		endcase
	endfunction

	power_state_type pwr_state_reg;
	seq_state_type   seq_state_reg;
	logic [7:0]  work_reg [NUM_SLOT];
	logic [7:0]  store_sel_reg;
	logic [3:0]  fault_rec_reg;
	logic [15:0] tick_cnt_reg;
	logic        ms_tick;
	logic [5:0]  on_ms_reg;
	logic [5:0]  off_ms_reg;
	logic [5:0]  uv_ms_reg [NUM_SW];
	logic [3:0]  uv_fire;
	logic [7:0]  refresh_ms_reg;
	logic [3:0]  seq_slot_reg;
	logic [7:0]  seq_addr;
	logic        seq_load_reg;
	logic        load_done_pulse;
	logic        refresh_mismatch;
	logic        fault_hold_reg;
	logic [5:0]  pulse_ms_reg;
	logic        en_prev_reg;
	logic        chip_on;
	logic        host_busy;
	logic        latch_evt;
	logic [4:0]  ch_off;
	logic [4:0]  disch_en;
	logic [NV_AW-1:0] mem_addr;
	logic        mem_wr;
	logic [7:0]  mem_rdata;
	logic [3:0]  host_slot;
	logic        host_in_range;
	logic        rd1_reg;
	logic        rd1_mem_reg;
	logic [7:0]  rd1_data_reg;

	assign chip_on       = VIN_ABOVE_RISE_IN & EN_PIN_IN;
	assign host_busy     = REG_WR_IN | REG_RD_IN;
	assign host_slot     = slot_of(REG_ADDR_IN);
	assign host_in_range = REG_ADDR_IN < 8'(NV_DEPTH);
	assign ms_tick       = tick_cnt_reg == 16'(CYCLES_PER_MS - 1);

	// Host access owns the store port; refresh waits
	assign seq_addr = addr_of(seq_slot_reg);
	assign mem_addr = host_busy ? REG_ADDR_IN[NV_AW-1:0] : seq_addr[NV_AW-1:0];
	assign mem_wr   = REG_WR_IN & host_in_range & store_sel_reg[STORE_COMMIT_BIT];

	nv_store_mem #(
		.DEPTH (NV_DEPTH),
		.AW    (NV_AW),
		.WIDTH (8)
	) u_store (
		.clk_in    (CLK_SYS_IN),
		.rst_in    (RST_IN),
		.addr_in   (mem_addr),
		.wr_in     (mem_wr),
		.wdata_in  (REG_WDATA_IN),
		.rdata_out (mem_rdata)
	);

	// Millisecond time base
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN || ms_tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= 16'(tick_cnt_reg + 16'h0001);
		end
	end

	// Power state
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			pwr_state_reg <= PWR_OFF;
		end else begin
			case (pwr_state_reg)
				PWR_OFF: begin
					if (chip_on) begin
						pwr_state_reg <= PWR_LOAD;
					end
				end
				PWR_LOAD: begin
					if (!chip_on) begin
						pwr_state_reg <= PWR_OFF;
					end else if (load_done_pulse) begin
						pwr_state_reg <= PWR_ON;
					end
				end
				PWR_ON: begin
					if (latch_evt) begin
						pwr_state_reg <= PWR_LATCH;
					end else if (!chip_on || VIN_DETECT_LOW_IN) begin
						pwr_state_reg <= PWR_DOWN;
					end
				end
				PWR_DOWN: begin
					if (&ch_off && off_ms_reg >= 6'(OFF_DELAY_MAX_MS + DISCHARGE_WINDOW_MS)) begin
						pwr_state_reg <= PWR_OFF;
					end
				end
				PWR_LATCH: begin
					if (!chip_on) begin
						pwr_state_reg <= PWR_OFF;
					end
				end
				default: pwr_state_reg <= PWR_OFF;
			endcase
		end
	end

	// Millisecond counts since lockout release and since power-off start
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN || pwr_state_reg == PWR_OFF) begin
			on_ms_reg <= '0;
		end else if (ms_tick && on_ms_reg != '1) begin
			on_ms_reg <= 6'(on_ms_reg + 6'h01);
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN || pwr_state_reg != PWR_DOWN) begin
			off_ms_reg <= '0;
		end else if (ms_tick && off_ms_reg != '1) begin
			off_ms_reg <= 6'(off_ms_reg + 6'h01);
		end
	end

	// Per-channel power-off delay compare and discharge enables
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			ch_off[i]   = off_ms_reg >= 6'(work_reg[SLOT_DLY0 + i][OFF_DLY_MSB:0] * OFF_STEP_MS);
			disch_en[i] = ~work_reg[SLOT_DISC][DISCH_MSB - i];
		end
	end

	// Undervoltage filters
	always_ff @(posedge CLK_SYS_IN) begin
		for (int i = 0; i < NUM_SW; i++) begin
			if (RST_IN || pwr_state_reg != PWR_ON || !UVP_IN[i]) begin
				uv_ms_reg[i] <= '0;
			end else if (ms_tick && uv_ms_reg[i] != UV_FILTER_MS) begin
				uv_ms_reg[i] <= 6'(uv_ms_reg[i] + 6'h01);
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_SW; i++) begin
			uv_fire[i] = UVP_IN[i] && uv_ms_reg[i] == UV_FILTER_MS;
		end
	end

	assign latch_evt = pwr_state_reg == PWR_ON && (|uv_fire || |SCP_IN);

	// Fault record, set wins over clear
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			en_prev_reg   <= 1'b0;
			fault_rec_reg <= '0;
		end else begin
			en_prev_reg <= EN_PIN_IN;
			if (pwr_state_reg == PWR_ON && |uv_fire) begin
				fault_rec_reg <= fault_rec_reg | uv_fire;
			end else if (work_reg[SLOT_LAST][CLR_SEL_BIT] ? VIN_BELOW_FALL_IN
			                                               : (en_prev_reg && !EN_PIN_IN)) begin
				fault_rec_reg <= '0;
			end
		end
	end

	// Latched fault hold and one-shot pulse
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN || pwr_state_reg == PWR_OFF) begin
			fault_hold_reg <= 1'b0;
		end else if (latch_evt && (|uv_fire || |SCP_IN[NUM_SW-1:1])) begin
			fault_hold_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			pulse_ms_reg <= '0;
		end else if ((latch_evt && SCP_IN[0]) ||
		             (refresh_mismatch && work_reg[SLOT_REFR][REFRESH_FAULT_BIT])) begin
			pulse_ms_reg <= 6'(FAULT_PULSE_MS + 6'h01);
		end else if (ms_tick && pulse_ms_reg != '0) begin
			pulse_ms_reg <= 6'(pulse_ms_reg - 6'h01);
		end
	end

	// Fault pin: overvoltage and overcurrent leave it released
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			FAULT_OE_N_OUT <= 1'b1;
		end else begin
			FAULT_OE_N_OUT <= !(fault_hold_reg || pulse_ms_reg != '0 || OTP_IN);
		end
	end
	assign FAULT_OUT = 1'b0;

	// Converter, discharge and reset outputs
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			CH_ENABLE_OUT   <= '0;
			DISCHARGE_OUT   <= '0;
			SWITCH_STOP_OUT <= '1;
			COMMON_VOLTAGE_OUT_CLAMP_OUT  <= 1'b0;
			RESET_N_OUT     <= 1'b0;
		end else begin
			COMMON_VOLTAGE_OUT_CLAMP_OUT <= COMMON_VOLTAGE_OUT_OCP_IN;
			case (pwr_state_reg)
				PWR_LOAD, PWR_ON: begin
					CH_ENABLE_OUT   <= pwr_state_reg == PWR_ON ? '1 : '0;
					SWITCH_STOP_OUT <= pwr_state_reg == PWR_ON ? (OVP_IN | SCP_IN) : '1;
					RESET_N_OUT     <= pwr_state_reg == PWR_ON && &PON_DELAY_DONE_IN;
					for (int i = 0; i < NUM_CH; i++) begin
						DISCHARGE_OUT[i] <= disch_en[i]
							? (on_ms_reg >= ON_DISCHARGE_START_MS &&
							   !(pwr_state_reg == PWR_ON && PON_DELAY_DONE_IN[i]))
							: pwr_state_reg == PWR_LOAD;
					end
				end
				PWR_DOWN: begin
					CH_ENABLE_OUT   <= ~ch_off;
					DISCHARGE_OUT   <= disch_en & ch_off;
					SWITCH_STOP_OUT <= ch_off[NUM_SW-1:0] | OVP_IN;
					RESET_N_OUT     <= work_reg[SLOT_DISC][RESET_SYNC_BIT] && !ch_off[2];
				end
				default: begin
					CH_ENABLE_OUT   <= '0;
					DISCHARGE_OUT   <= '0;
					SWITCH_STOP_OUT <= '1;
					RESET_N_OUT     <= 1'b0;
				end
			endcase
		end
	end

	// Settings load and auto refresh sequencer
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN || pwr_state_reg != PWR_ON || !work_reg[SLOT_REFR][REFRESH_EN_BIT]) begin
			refresh_ms_reg <= '0;
		end else if (ms_tick) begin
			refresh_ms_reg <= refresh_ms_reg >= refresh_ms(work_reg[SLOT_REFR][REFRESH_INT_LSB +: 2])
				? 8'h00 : 8'(refresh_ms_reg + 8'h01);
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			seq_state_reg <= SEQ_IDLE;
			seq_slot_reg  <= '0;
			seq_load_reg  <= 1'b0;
		end else begin
			case (seq_state_reg)
				SEQ_IDLE: begin
					seq_slot_reg <= '0;
					if (pwr_state_reg == PWR_OFF && chip_on) begin
						seq_load_reg  <= 1'b1;
						seq_state_reg <= SEQ_READ;
					end else if (ms_tick && refresh_ms_reg != '0 && refresh_ms_reg >=
					             refresh_ms(work_reg[SLOT_REFR][REFRESH_INT_LSB +: 2])) begin
						seq_load_reg  <= 1'b0;
						seq_state_reg <= SEQ_READ;
					end
				end
				SEQ_READ: begin
					if (!host_busy) begin
						seq_state_reg <= SEQ_CMP;
					end
				end
				SEQ_CMP: begin
					seq_slot_reg  <= 4'(seq_slot_reg + 4'h1);
					seq_state_reg <= seq_slot_reg == SLOT_LAST ? SEQ_IDLE : SEQ_READ;
				end
				default: seq_state_reg <= SEQ_IDLE;
			endcase
		end
	end

	assign load_done_pulse  = seq_state_reg == SEQ_CMP && seq_load_reg && seq_slot_reg == SLOT_LAST;
	assign refresh_mismatch = seq_state_reg == SEQ_CMP && !seq_load_reg &&
	                          work_reg[seq_slot_reg] != mem_rdata;

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN || pwr_state_reg == PWR_OFF) begin
			SETTINGS_LOAD_DONE_OUT <= 1'b0;
		end else if (load_done_pulse) begin
			SETTINGS_LOAD_DONE_OUT <= 1'b1;
		end
	end

	// Working registers: host write first, then load or restore
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			for (int i = 0; i < NUM_SLOT; i++) begin
				work_reg[i] <= WORK_RESET;
			end
			store_sel_reg <= STORE_RESET;
		end else if (REG_WR_IN) begin
			if (host_slot != SLOT_NONE) begin
				work_reg[host_slot] <= REG_WDATA_IN;
			end
			if (REG_ADDR_IN == ADDR_STORE_SEL) begin
				store_sel_reg <= REG_WDATA_IN;
			end
		end else if (seq_state_reg == SEQ_CMP && (seq_load_reg || refresh_mismatch)) begin
			work_reg[seq_slot_reg] <= mem_rdata;
		end
	end

	// Setting outputs
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			SLEW_POS_BOOST_OUT <= '0;
			SLEW_NEG_RAIL_OUT  <= '0;
			SLEW_GATE_LOW_OUT  <= '0;
			SLEW_GATE_HIGH_OUT <= '0;
			SPREAD_SEL_OUT     <= '0;
		end else begin
			SLEW_POS_BOOST_OUT <= work_reg[SLOT_SLEW][7:6];
			SLEW_NEG_RAIL_OUT  <= work_reg[SLOT_SLEW][5:4];
			SLEW_GATE_LOW_OUT  <= work_reg[SLOT_SLEW][3:2];
			SLEW_GATE_HIGH_OUT <= work_reg[SLOT_SLEW][1:0];
			SPREAD_SEL_OUT     <= work_reg[SLOT_SPRD][SPREAD_LSB +: 2];
		end
	end

	// Two-stage read: select, then data out
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			rd1_reg        <= 1'b0;
			rd1_mem_reg    <= 1'b0;
			rd1_data_reg   <= '0;
			REG_RDATA_OUT  <= '0;
			REG_RVALID_OUT <= 1'b0;
		end else begin
			rd1_reg     <= REG_RD_IN && !REG_WR_IN;
			rd1_mem_reg <= store_sel_reg[STORE_READ_BIT] && host_in_range;
			if (host_slot != SLOT_NONE) begin
				rd1_data_reg <= work_reg[host_slot];
			end else if (REG_ADDR_IN == ADDR_FAULT_REC) begin
				rd1_data_reg <= {4'h0, fault_rec_reg};
			end else if (REG_ADDR_IN == ADDR_STORE_SEL) begin
				rd1_data_reg <= store_sel_reg;
			end else begin
				rd1_data_reg <= '0;
			end
			REG_RVALID_OUT <= rd1_reg;
			if (rd1_reg) begin
				REG_RDATA_OUT <= rd1_mem_reg ? mem_rdata : rd1_data_reg;
			end
		end
	end

endmodule

/* tb/reg_host_model.sv */
// Host model for the register port
`timescale 1ns/100ps
module reg_host_model (
	// Clock
	input  wire logic       clk_in,
	// Register port
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            wr_out,
	output logic            rd_out,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in
);
	initial begin
		{addr_out, wdata_out, wr_out, rd_out} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		n = 0;
		while (rvalid_in !== 1'b1 && n < 6) begin
			@(posedge clk_in);
			n++;
		end
		d = rdata_in;
		if (n == 6) d = 'x;
	endtask
endmodule

/* tb/panel_pmic_checker.sv */
// Port assertions of the panel power module control logic
`timescale 1ns/100ps
module panel_pmic_checker
	import panel_pmic_pkg::*;
#(
	parameter int CYCLES_PER_MS = 20
) (
	// Inputs
	input wire logic       CLK_SYS_IN,
	input wire logic       RST_IN,
	input wire logic [3:0] OVP_IN,
	input wire logic [3:0] SCP_IN,
	input wire logic       OTP_IN,
	input wire logic       COMMON_VOLTAGE_OUT_OCP_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic       REG_WR_IN,
	input wire logic       REG_RD_IN,
	// Outputs
	input wire logic       REG_RVALID_OUT,
	input wire logic [4:0] CH_ENABLE_OUT,
	input wire logic [3:0] SWITCH_STOP_OUT,
	input wire logic       COMMON_VOLTAGE_OUT_CLAMP_OUT,
	input wire logic [1:0] SLEW_POS_BOOST_OUT,
	input wire logic       FAULT_OUT,
	input wire logic       FAULT_OE_N_OUT
);
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (RST_IN);
	rd_latency_a: assert property (REG_RD_IN && !REG_WR_IN |-> ##2 REG_RVALID_OUT)
		else $error("read answer late");
	rvalid_cause_a: assert property (REG_RVALID_OUT |-> $past(REG_RD_IN, 2))
		else $error("answer without read");
	fault_drive_a: assert property (FAULT_OUT == 1'b0)
		else $error("fault pin driven high");
	ovp_stop_a: assert property (OVP_IN[0] && CH_ENABLE_OUT[0] |-> ##[1:2] SWITCH_STOP_OUT[0])
		else $error("switching not stopped");
	clamp_follow_a: assert property (COMMON_VOLTAGE_OUT_OCP_IN && CH_ENABLE_OUT[4] |-> ##[1:2] COMMON_VOLTAGE_OUT_CLAMP_OUT)
		else $error("clamp missing");
	otp_fault_a: assert property (OTP_IN |=> !FAULT_OE_N_OUT)
		else $error("fault pin not low");
	scp_off_a: assert property (SCP_IN[1] && CH_ENABLE_OUT[1] |-> ##[1:4] CH_ENABLE_OUT == 5'h00)
		else $error("no shutdown");
	slew_copy_a: assert property (REG_WR_IN && REG_ADDR_IN == ADDR_SLEW |->
		##2 SLEW_POS_BOOST_OUT == $past(REG_WDATA_IN[7:6], 2))
		else $error("slew field wrong");
endmodule
bind panel_pmic_shutdown_fault_ctrl panel_pmic_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk_i (.*);

/* tb/panel_pmic_shutdown_fault_ctrl_tb.sv */
// Self-checking bench of the panel power module control logic
`timescale 1ns/100ps
module panel_pmic_shutdown_fault_ctrl_tb;
	import panel_pmic_pkg::*;
	localparam int CPM = 20;
	logic       clk, rst, en, vin_ok, vin_low, below, otp, overcurrent_protection, wr, rd, rvalid;
	logic       load_done, rst_n, f_oe_n, clamp;
	logic [3:0] overvoltage_protection, undervoltage_protection, short_circuit_protection, sw_stop;
	logic [4:0] pon, ch_en, dis;
	logic [7:0] addr, wdata, rdata, rd8;
	logic [1:0] s_pos, s_neg, s_gl, s_gh, spread;
	logic [7:0] m [int];
	logic [7:0] tab [8] = '{ADDR_SLEW, ADDR_SPREAD, ADDR_REFRESH, ADDR_OFF_DLY_POS,
		ADDR_OFF_DLY_NEG, ADDR_OFF_DLY_GH, ADDR_OFF_DLY_GL, ADDR_OFF_DLY_CV};
	int         err_total, checked, seed, cnt;
	int         dq [$];
	int         toff [5];

	reg_host_model host_i (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
		.rd_out(rd), .rdata_in(rdata), .rvalid_in(rvalid));
	panel_pmic_shutdown_fault_ctrl #(.CYCLES_PER_MS(CPM)) panel_pmic_shutdown_fault_ctrl_i (
		.CLK_SYS_IN(clk), .RST_IN(rst), .EN_PIN_IN(en), .VIN_ABOVE_RISE_IN(vin_ok),
		.VIN_BELOW_FALL_IN(below), .VIN_DETECT_LOW_IN(vin_low), .PON_DELAY_DONE_IN(pon),
		.OVP_IN(overvoltage_protection), .UVP_IN(undervoltage_protection), .SCP_IN(short_circuit_protection), .OTP_IN(otp), .COMMON_VOLTAGE_OUT_OCP_IN(overcurrent_protection),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .CH_ENABLE_OUT(ch_en),
		.DISCHARGE_OUT(dis), .SWITCH_STOP_OUT(sw_stop), .COMMON_VOLTAGE_OUT_CLAMP_OUT(clamp),
		.RESET_N_OUT(rst_n), .SETTINGS_LOAD_DONE_OUT(load_done),
		.SLEW_POS_BOOST_OUT(s_pos), .SLEW_NEG_RAIL_OUT(s_neg), .SLEW_GATE_LOW_OUT(s_gl),
		.SLEW_GATE_HIGH_OUT(s_gh), .SPREAD_SEL_OUT(spread), .FAULT_OUT(), .FAULT_OE_N_OUT(f_oe_n));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_rng(input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("wrong value t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic results();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic ms(input int n);
		repeat (n * CPM) @(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		host_i.rd(a, rd8);
		cmp(rd8, exp);
	endtask
	// Counts cycles with the fault pin pulled low
	task automatic lowcnt(input int n);
		cnt = 0;
		repeat (n) begin
			@(posedge clk);
			if (f_oe_n === 1'b0) cnt++;
		end
	endtask
	task automatic pwr_off();
		en <= 1'b0;
		vin_low <= 1'b0;
		ms(50);
	endtask
	task automatic pwr_on();
		int n;
		n = 0;
		pon <= 5'h00;
		en <= 1'b1;
		while (load_done !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		ms(2);
		cmp({3'h0, dis}, 8'h1f);
		pon <= 5'h1f;
		ms(1);
		cmp({3'h0, dis}, 8'h00);
		cmp({3'h0, ch_en}, 8'h1f);
	endtask

	initial begin
		#(25 * 40000);
		err_total++;
		results();
	end
	initial begin
		logic [7:0] a, d, sv;
		seed = 28;
		{err_total, checked} = '0;
		{en, vin_low, below, otp, overcurrent_protection, overvoltage_protection, undervoltage_protection, short_circuit_protection, pon} = '0;
		vin_ok = 1'b1;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		pwr_on();
		foreach (tab[i]) rdc(tab[i], 8'h00);
		host_i.wr(8'h40, 8'h5a);
		rdc(8'h40, 8'h00);
		host_i.wr(ADDR_FAULT_REC, 8'hff);
		rdc(ADDR_FAULT_REC, 8'h00);
		foreach (tab[i]) m[tab[i]] = 8'h00;
		for (int i = 0; i < 16; i++) begin
			a = tab[$unsigned($random(seed)) % 8];
			d = $random(seed);
			if (a == ADDR_REFRESH) d[0] = 1'b0;
			host_i.wr(a, d);
			m[a] = d;
			rdc(a, m[a]);
			cmp({s_pos, s_neg, s_gl, s_gh}, m[ADDR_SLEW]);
			cmp({3'h0, spread, 3'h0}, m[ADDR_SPREAD] & 8'h18);
		end
		sv = $random(seed);
		host_i.wr(ADDR_STORE_SEL, 8'h80);
		host_i.wr(ADDR_SLEW, sv);
		host_i.wr(ADDR_STORE_SEL, 8'h00);
		host_i.wr(ADDR_SLEW, ~sv);
		host_i.wr(ADDR_STORE_SEL, 8'h01);
		rdc(ADDR_SLEW, sv);
		host_i.wr(ADDR_STORE_SEL, 8'h00);
		rdc(ADDR_SLEW, ~sv);
		// All channels in use, discharge on, reset low at power-off start
		host_i.wr(ADDR_DISCHARGE, 8'h00);
		for (int i = 0; i < 5; i++) begin
			dq.push_back($unsigned($random(seed)) % 8);
			host_i.wr(ADDR_OFF_DLY_POS + 8'(i), 8'(dq[i]));
			toff[i] = -1;
		end
		vin_low <= 1'b1;
		for (int c = 0; c < 20 * CPM; c++) begin
			@(posedge clk);
			if (c == 3) cmp({7'h00, rst_n}, 8'h00);
			for (int i = 0; i < 5; i++) begin
				if (toff[i] < 0 && ch_en[i] === 1'b0) toff[i] = c;
				if (toff[i] >= 0 && c == toff[i] + 3) cmp({7'h00, dis[i]}, 8'h01);
			end
		end
		foreach (toff[i]) cmp_rng(toff[i], (2 * dq[i] - 1) * CPM, (2 * dq[i] + 1) * CPM + 4);
		pwr_off();
		pwr_on();
		undervoltage_protection <= 4'h4;
		ms(45);
		cmp({7'h00, f_oe_n}, 8'h01);
		ms(8);
		cmp({7'h00, f_oe_n}, 8'h00);
		cmp({3'h0, ch_en}, 8'h00);
		rdc(ADDR_FAULT_REC, 8'h04);
		undervoltage_protection <= 4'h0;
		pwr_off();
		rdc(ADDR_FAULT_REC, 8'h00);
		for (int r = 0; r < 2; r++) begin
			pwr_on();
			short_circuit_protection <= 4'(1 << r);
			lowcnt(4 * CPM);
			if (r == 0) cmp_rng(cnt, 1, 2 * CPM + 2);
			else cmp_rng(cnt, 4 * CPM - 4, 4 * CPM);
			cmp({3'h0, ch_en}, 8'h00);
			short_circuit_protection <= 4'h0;
			pwr_off();
		end
		pwr_on();
		{overvoltage_protection, overcurrent_protection} <= 5'h03;
		ms(1);
		cmp({7'h00, sw_stop[0]}, 8'h01);
		cmp({6'h00, clamp, f_oe_n}, 8'h03);
		{overvoltage_protection, overcurrent_protection} <= 5'h00;
		ms(1);
		cmp({6'h00, clamp, sw_stop[0]}, 8'h00);
		otp <= 1'b1;
		ms(1);
		otp <= 1'b0;
		ms(1);
		cmp({7'h00, f_oe_n}, 8'h01);
		// Refresh setting kept in the store so that only the slew slot differs
		host_i.wr(ADDR_STORE_SEL, 8'h80);
		host_i.wr(ADDR_REFRESH, 8'h09);
		host_i.wr(ADDR_STORE_SEL, 8'h00);
		host_i.wr(ADDR_SLEW, ~sv);
		lowcnt(25 * CPM);
		cmp_rng(cnt, 1, 2 * CPM + 2);
		rdc(ADDR_SLEW, sv);
		results();
	end
endmodule
